//--- hdl/mae_core.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - divide, multiply, add with and without carry
// - subtract with borrow, AND, OR, XOR, NOT
// - arithmetic treats operands as unsigned, except the overflow flag of add and subtract, which marks signed overflow
// - increment or decrement any 8-bit operand
// - rotate, swap, clear, complement, adjust accumulator only
// - operands from accumulator, B or datapath
// - carry, overflow, parity kept in flag word
// - opcodes decoded compatibly with legacy instruction set
// - add opcodes and their cycle counts
// - add-with-carry opcodes and cycle counts
// - subtract-with-borrow opcodes and cycle counts
// - increment opcodes and cycle counts
// - decrement opcodes and cycle counts
// - AND opcodes and cycle counts
// - OR opcodes and cycle counts
// - XOR opcodes and cycle counts
// - four accumulator rotates, one cycle each
// - nibble swap opcode C4, one cycle
// - moves into accumulator and cycle counts
// - moves into bank register and cycle counts
// - moves into direct location and cycle counts
// - each instruction cycle is one clock
module mae_core (
  input wire logic clock,
  input wire logic rstn,
  input wire logic issue,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  output logic busy_ff,
  output logic done_ff,
  output logic [3:0] cycles_ff,
  output logic [7:0] result_ff,
  output logic result_wr_ff,
  output logic [7:0] primary_operand_reg_ff,
  output logic [7:0] second_operand_ff,
  output logic [7:0] flag_word_register_ff,
  output logic [15:0] data_pointer_pair_ff,
  output logic illegal_ff
);
  import mae_pkg::*;
  // ****************************************
  // opcode decode
  // ****************************************
  wire logic [4:0] hi = opcode[7:3];
  wire logic is_rn = opcode[3];
  wire logic [2:0] lo = opcode[2:0];
  wire logic grp_add = (opcode[7:4] == 4'h2);
  wire logic grp_addc = (opcode[7:4] == 4'h3);
  wire logic grp_subb = (opcode[7:4] == 4'h9);
  wire logic grp_and = (opcode[7:4] == 4'h5);
  wire logic grp_or = (opcode[7:4] == 4'h4);
  wire logic grp_xor = (opcode[7:4] == 4'h6);
  wire logic acc_form = is_rn | (lo >= 3'h4); // forms with accumulator as target
  wire logic arith_grp = grp_add | grp_addc | grp_subb;
  wire logic logic_grp = grp_and | grp_or | grp_xor;
  wire logic arith_op = (arith_grp | logic_grp) & acc_form;
  wire logic logic_mem = logic_grp & ((lo == 3'h2) | (lo == 3'h3));
  wire logic inc_grp = (opcode[7:4] == 4'h0) & (is_rn | (lo >= 3'h4));
  wire logic dec_grp = (opcode[7:4] == 4'h1) & (is_rn | (lo >= 3'h4));
  wire logic mov_a = (hi == 5'h1d) | (opcode == 8'he5) | (opcode == 8'he6) | (opcode == 8'he7)
    | (opcode == 8'h74);
  wire logic mov_rn = (hi == 5'h1f) | (hi == 5'h15) | (hi == 5'h0f);
  wire logic mov_dir = (opcode == 8'hf5) | (hi == 5'h11) | (opcode == 8'h85) | (opcode == 8'h86)
    | (opcode == 8'h87);
  wire logic mov_ok = mov_a | mov_rn | mov_dir;
  wire logic acc_only = (opcode == 8'he4) | (opcode == 8'hf4) | (opcode == 8'h23) | (opcode == 8'h33)
    | (opcode == 8'h03) | (opcode == 8'h13) | (opcode == 8'hc4) | (opcode == 8'hd4);
  wire logic muldiv = (opcode == 8'ha4) | (opcode == 8'h84);
  wire logic inc_dp = (opcode == 8'ha3);
  wire logic legal = arith_op | logic_mem | inc_grp | dec_grp | mov_ok | acc_only | muldiv | inc_dp;
  // ****************************************
  // operation select
  // ****************************************
  mae_op_t dec_op;
  always_comb begin
    dec_op = MAE_OP_NONE;
    if (grp_add & arith_op) begin
      dec_op = MAE_OP_ADD;
    end else if (grp_addc & arith_op) begin
      dec_op = MAE_OP_ADDC;
    end else if (grp_subb & arith_op) begin
      dec_op = MAE_OP_SUBB;
    end else if (grp_and & (arith_op | logic_mem)) begin
      dec_op = MAE_OP_AND;
    end else if (grp_or & (arith_op | logic_mem)) begin
      dec_op = MAE_OP_OR;
    end else if (grp_xor & (arith_op | logic_mem)) begin
      dec_op = MAE_OP_XOR;
    end else if (inc_grp) begin
      dec_op = MAE_OP_INC;
    end else if (dec_grp) begin
      dec_op = MAE_OP_DEC;
    end else if (inc_dp) begin
      dec_op = MAE_OP_INCDP;
    end else if (mov_ok) begin
      dec_op = MAE_OP_MOV;
    end else begin
      unique case (opcode)
        8'he4: dec_op = MAE_OP_CLR;
        8'hf4: dec_op = MAE_OP_NOT;
        8'h23: dec_op = MAE_OP_RL;
        8'h33: dec_op = MAE_OP_RLC;
        8'h03: dec_op = MAE_OP_RR;
        8'h13: dec_op = MAE_OP_RRC;
        8'hc4: dec_op = MAE_OP_SWAP;
        8'hd4: dec_op = MAE_OP_DA;
        8'ha4: dec_op = MAE_OP_MUL;
        8'h84: dec_op = MAE_OP_DIV;
        default: dec_op = MAE_OP_NONE;
      endcase
    end
  end
  // ****************************************
  // cycle count per opcode
  // ****************************************
  logic [3:0] dec_cyc;
  always_comb begin
    dec_cyc = 4'h1;
    if (arith_op) begin
      dec_cyc = is_rn ? 4'h1 : 4'h2;
    end else if (logic_mem) begin
      dec_cyc = lo[0] ? 4'h4 : 4'h3;
    end else if (inc_grp | dec_grp) begin
      dec_cyc = (lo == 3'h4) & ~is_rn ? 4'h1 : (is_rn ? 4'h2 : 4'h3);
    end else if (mov_a) begin
      dec_cyc = (hi == 5'h1d) ? 4'h1 : 4'h2;
    end else if (mov_rn) begin
      dec_cyc = (hi == 5'h15) ? 4'h4 : 4'h2;
    end else if (mov_dir) begin
      dec_cyc = ((opcode == 8'hf5) | (hi == 5'h11)) ? 4'h3 : 4'h4;
    end else if (muldiv) begin
      dec_cyc = 4'(MUL_DIV_CYCLES);
    end
  end
  // ****************************************
  // operand routing
  // ****************************************
  // multiply and divide leave the low product or quotient in the accumulator
  wire logic to_acc = arith_op | acc_only | mov_a | muldiv | ((inc_grp | dec_grp) & (lo == 3'h4) & ~is_rn);
  wire logic src_acc_as_b = mov_dir & (opcode == 8'hf5) | (hi == 5'h1f) | (logic_mem & ~lo[0]);
  wire logic [7:0] alu_a_sel = (logic_mem | mov_ok | ((inc_grp | dec_grp) & ~to_acc))
    ? (logic_mem ? operand : 8'h00) | (((inc_grp | dec_grp) & ~to_acc) ? operand : 8'h00)
    : primary_operand_reg_ff;
  wire logic [7:0] alu_b_sel = muldiv ? second_operand_ff
    : (src_acc_as_b ? primary_operand_reg_ff : operand);
  mae_alu_if alu_bus ();
  assign alu_bus.op = dec_op;
  assign alu_bus.a = alu_a_sel;
  assign alu_bus.b = alu_b_sel;
  assign alu_bus.cy_in = flag_word_register_ff[FLAG_CY];
  assign alu_bus.ac_in = flag_word_register_ff[FLAG_AC];
  mae_alu u_alu (
    .bus(alu_bus)
  );
  // ****************************************
  // next state
  // ****************************************
  logic [3:0] cnt_ff;
  wire logic start = issue & ~busy_ff;
  wire logic last = busy_ff & (cnt_ff == 4'h1);
  logic [7:0] hold_res_ff;
  logic [7:0] hold_hi_ff;
  logic hold_acc_ff;
  logic hold_b_ff;
  logic [7:0] hold_flag_ff;
  wire logic flag_upd = arith_op & arith_grp | muldiv | (dec_op == MAE_OP_RLC) | (dec_op == MAE_OP_RRC)
    | (dec_op == MAE_OP_DA);
  wire logic ov_upd = arith_op & arith_grp | muldiv;
  logic [7:0] nxt_flag;
  always_comb begin
    nxt_flag = flag_word_register_ff;
    if (flag_upd) begin
      nxt_flag[FLAG_CY] = alu_bus.cy_out;
      nxt_flag[FLAG_AC] = alu_bus.ac_out;
    end
    if (ov_upd) begin
      nxt_flag[FLAG_OV] = alu_bus.ov_out;
    end
  end
  // ****************************************
  // sequencing, one clock per cycle
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
      cycles_ff <= 4'h0;
      illegal_ff <= 1'b0;
      hold_res_ff <= 8'h00;
      hold_hi_ff <= 8'h00;
      hold_acc_ff <= 1'b0;
      hold_b_ff <= 1'b0;
      hold_flag_ff <= FLAG_RST;
    end else begin
      done_ff <= last | (start & (dec_cyc == 4'h1));
      if (start) begin
        busy_ff <= (dec_cyc != 4'h1);
        cnt_ff <= dec_cyc - 4'h1;
        cycles_ff <= dec_cyc;
        illegal_ff <= ~legal;
        hold_res_ff <= alu_bus.res;
        hold_hi_ff <= alu_bus.res_hi;
        hold_acc_ff <= to_acc & legal;
        hold_b_ff <= muldiv;
        hold_flag_ff <= nxt_flag;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
        busy_ff <= ~last;
      end
    end
  end
  wire logic commit = last | (start & (dec_cyc == 4'h1));
  wire logic [7:0] com_res = busy_ff ? hold_res_ff : alu_bus.res;
  wire logic com_acc = busy_ff ? hold_acc_ff : (to_acc & legal);
  wire logic com_b = busy_ff ? hold_b_ff : muldiv;
  wire logic [7:0] com_flag = busy_ff ? hold_flag_ff : nxt_flag;
  wire logic [7:0] com_acc_val = com_acc ? com_res : primary_operand_reg_ff;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      primary_operand_reg_ff <= ACC_RST;
      second_operand_ff <= B_RST;
      flag_word_register_ff <= FLAG_RST;
      data_pointer_pair_ff <= DP_RST;
      result_ff <= 8'h00;
      result_wr_ff <= 1'b0;
    end else begin
      // pointer increment and unknown opcodes put nothing on the datapath
      result_wr_ff <= commit & ~com_acc & ~(busy_ff ? 1'b0 : ~legal | inc_dp) & ~com_b;
      if (commit) begin
        result_ff <= com_res;
        primary_operand_reg_ff <= com_acc_val;
        flag_word_register_ff <= {com_flag[7:1], ^com_acc_val};
        if (com_b) begin
          second_operand_ff <= busy_ff ? hold_hi_ff : alu_bus.res_hi;
        end
        if (~busy_ff & inc_dp) begin
          data_pointer_pair_ff <= data_pointer_pair_ff + 16'h0001;
        end
      end
    end
  end
endmodule // mae_core
`default_nettype wire

//--- hdl/mae_pkg.sv
package mae_pkg;
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int DATA_W = 8;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] B_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [15:0] DP_RST = 16'h0000;
  // ****************************************
  // flag word bit positions
  // ****************************************
  localparam int FLAG_CY = 7;
  localparam int FLAG_AC = 6;
  localparam int FLAG_OV = 2;
  localparam int FLAG_P = 0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PER_CYCLE = 1;
  localparam int MUL_DIV_CYCLES = 5;
  // ****************************************
  // operand sources and operations
  // ****************************************
  typedef enum logic [1:0] {
    MAE_SRC_REG = 2'b00,
    MAE_SRC_DIRECT = 2'b01,
    MAE_SRC_INDIR = 2'b10,
    MAE_SRC_IMM = 2'b11
  } mae_src_t;
  typedef enum logic [4:0] {
    MAE_OP_NONE = 5'b00000,
    MAE_OP_ADD = 5'b00001,
    MAE_OP_ADDC = 5'b00010,
    MAE_OP_SUBB = 5'b00011,
    MAE_OP_INC = 5'b00100,
    MAE_OP_DEC = 5'b00101,
    MAE_OP_AND = 5'b00110,
    MAE_OP_OR = 5'b00111,
    MAE_OP_XOR = 5'b01000,
    MAE_OP_NOT = 5'b01001,
    MAE_OP_CLR = 5'b01010,
    MAE_OP_RL = 5'b01011,
    MAE_OP_RLC = 5'b01100,
    MAE_OP_RR = 5'b01101,
    MAE_OP_RRC = 5'b01110,
    MAE_OP_SWAP = 5'b01111,
    MAE_OP_DA = 5'b10000,
    MAE_OP_MUL = 5'b10001,
    MAE_OP_DIV = 5'b10010,
    MAE_OP_MOV = 5'b10011,
    MAE_OP_INCDP = 5'b10100
  } mae_op_t;
endpackage

//--- hdl/mae_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mae_alu_if;
  import mae_pkg::*;
  mae_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cy_in;
  logic ac_in;
  logic [7:0] res;
  logic [7:0] res_hi;
  logic cy_out;
  logic ac_out;
  logic ov_out;
  modport core (output op, output a, output b, output cy_in, output ac_in,
    input res, input res_hi, input cy_out, input ac_out, input ov_out);
  modport alu (input op, input a, input b, input cy_in, input ac_in,
    output res, output res_hi, output cy_out, output ac_out, output ov_out);
endinterface
`default_nettype wire

//--- hdl/mae_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mae_alu (
  mae_alu_if.alu bus
);
  import mae_pkg::*;
  // ****************************************
  // unsigned arithmetic and logic
  // ****************************************
  wire logic [8:0] add_s = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cy_in & (bus.op == MAE_OP_ADDC)};
  wire logic [4:0] add_h = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cy_in & (bus.op == MAE_OP_ADDC)};
  wire logic [8:0] sub_s = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cy_in};
  wire logic [4:0] sub_h = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cy_in};
  wire logic [15:0] prod = {8'h00, bus.a} * {8'h00, bus.b};
  wire logic div_zero = (bus.b == 8'h00);
  wire logic [7:0] quot = div_zero ? 8'hff : bus.a / bus.b;
  wire logic [7:0] remd = div_zero ? bus.a : bus.a % bus.b;
  wire logic da_lo = (bus.a[3:0] > 4'h9) | bus.ac_in;
  wire logic [8:0] da_1 = {1'b0, bus.a} + (da_lo ? 9'h006 : 9'h000);
  wire logic da_hi = (da_1[7:4] > 4'h9) | da_1[8] | bus.cy_in;
  wire logic [8:0] da_2 = da_1 + (da_hi ? 9'h060 : 9'h000);
  always_comb begin
    bus.res = bus.a;
    bus.res_hi = 8'h00;
    bus.cy_out = bus.cy_in;
    bus.ac_out = bus.ac_in;
    bus.ov_out = 1'b0;
    unique case (bus.op)
      MAE_OP_ADD, MAE_OP_ADDC: begin
        bus.res = add_s[7:0];
        bus.cy_out = add_s[8];
        bus.ac_out = add_h[4];
        bus.ov_out = (bus.a[7] == bus.b[7]) & (add_s[7] != bus.a[7]);
      end
      MAE_OP_SUBB: begin
        bus.res = sub_s[7:0];
        bus.cy_out = sub_s[8];
        bus.ac_out = sub_h[4];
        bus.ov_out = (bus.a[7] != bus.b[7]) & (sub_s[7] != bus.a[7]);
      end
      MAE_OP_INC: bus.res = bus.a + 8'h01;
      MAE_OP_DEC: bus.res = bus.a - 8'h01;
      MAE_OP_AND: bus.res = bus.a & bus.b;
      MAE_OP_OR: bus.res = bus.a | bus.b;
      MAE_OP_XOR: bus.res = bus.a ^ bus.b;
      MAE_OP_NOT: bus.res = ~bus.a;
      MAE_OP_CLR: bus.res = 8'h00;
      MAE_OP_RL: bus.res = {bus.a[6:0], bus.a[7]};
      MAE_OP_RR: bus.res = {bus.a[0], bus.a[7:1]};
      MAE_OP_RLC: begin
        bus.res = {bus.a[6:0], bus.cy_in};
        bus.cy_out = bus.a[7];
      end
      MAE_OP_RRC: begin
        bus.res = {bus.cy_in, bus.a[7:1]};
        bus.cy_out = bus.a[0];
      end
      MAE_OP_SWAP: bus.res = {bus.a[3:0], bus.a[7:4]};
      MAE_OP_DA: begin
        bus.res = da_2[7:0];
        bus.cy_out = bus.cy_in | da_2[8] | da_1[8];
      end
      MAE_OP_MUL: begin
        bus.res = prod[7:0];
        bus.res_hi = prod[15:8];
        bus.cy_out = 1'b0;
        bus.ov_out = (prod[15:8] != 8'h00);
      end
      MAE_OP_DIV: begin
        bus.res = quot;
        bus.res_hi = remd;
        bus.cy_out = 1'b0;
        bus.ov_out = div_zero;
      end
      MAE_OP_MOV: bus.res = bus.b;
      default: bus.res = bus.a;
    endcase
  end
endmodule // mae_alu
`default_nettype wire

//--- test/mae_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mae_core_checker
  import mae_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic issue,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic busy_ff,
  input wire logic done_ff,
  input wire logic [3:0] cycles_ff,
  input wire logic [7:0] result_ff,
  input wire logic result_wr_ff,
  input wire logic [7:0] primary_operand_reg_ff,
  input wire logic [7:0] flag_word_register_ff,
  input wire logic [15:0] data_pointer_pair_ff
);
  // ********
  // port timing and result checks
  // ********
  wire logic take;
  assign take = issue && !busy_ff;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_add_reg_one: assert property (take && opcode[7:3] == 5'h05 |=>
    done_ff && !busy_ff && cycles_ff == 4'h1)
    else $error("register add not done in one cycle");
  chk_add_reg_sum: assert property (take && opcode[7:3] == 5'h05 |=>
    {flag_word_register_ff[FLAG_CY], primary_operand_reg_ff} == $past(primary_operand_reg_ff) + $past(operand))
    else $error("register add sum or carry wrong");
  chk_add_dir_two: assert property (take && opcode == 8'h25 |=>
    busy_ff && cycles_ff == 4'h2 ##1 done_ff && !busy_ff)
    else $error("direct add not two cycles");
  chk_mul_five: assert property (take && opcode == 8'hA4 |=> busy_ff [*4] ##1 done_ff && !busy_ff)
    else $error("multiply not five cycles");
  chk_swap_nib: assert property (take && opcode == 8'hC4 |=> done_ff &&
    {primary_operand_reg_ff[3:0], primary_operand_reg_ff[7:4]} == $past(primary_operand_reg_ff))
    else $error("nibble swap wrong");
  chk_and_direct: assert property (take && opcode == 8'h52 |=>
    busy_ff ##1 busy_ff ##1 done_ff && result_wr_ff &&
    result_ff == ($past(operand, 3) & $past(primary_operand_reg_ff, 3)))
    else $error("and to direct wrong");
  chk_parity_acc: assert property (flag_word_register_ff[FLAG_P] == ^primary_operand_reg_ff)
    else $error("parity does not follow accumulator");
  chk_wr_at_done: assert property (result_wr_ff |-> done_ff)
    else $error("datapath write outside completion");
  chk_busy_hold: assert property (busy_ff && $past(busy_ff) |-> $stable(cycles_ff))
    else $error("cycle count changed while busy");
  chk_busy_end: assert property ($fell(busy_ff) |-> done_ff)
    else $error("busy ended without completion");
  chk_data_pointer_pair_inc: assert property (take && opcode == 8'hA3 |=>
    data_pointer_pair_ff == $past(data_pointer_pair_ff) + 16'h0001)
    else $error("data pointer increment wrong");
  cover property (take && opcode == 8'hA4);
  cover property (busy_ff && issue);
  cover property (result_wr_ff);
  cover property (take && opcode == 8'h84);
endmodule // mae_core_checker
bind mae_core mae_core_checker chk_u (.clock, .rstn, .issue, .opcode, .operand, .busy_ff, .done_ff, .cycles_ff,
  .result_ff, .result_wr_ff, .primary_operand_reg_ff, .flag_word_register_ff, .data_pointer_pair_ff);
`default_nettype wire

//--- test/mae_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module mae_core_test;
  import mae_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic issue = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operand = 8'h00;
  logic busy_ff, done_ff, result_wr_ff, illegal_ff;
  logic [3:0] cycles_ff;
  logic [7:0] result_ff, primary_operand_reg_ff, second_operand_ff, flag_word_register_ff;
  logic [15:0] data_pointer_pair_ff;
  int fail_count = 0;
  int n_tests = 0;
  int seed = 32'h1d66_f5ca;
  int m_a, m_b, m_cy, m_ac, m_ov, m_dp, m_r, m_il;
  int ops[$] = '{8'h28, 8'h25, 8'h24, 8'h26, 8'h38, 8'h35, 8'h36, 8'h34, 8'h98, 8'h95, 8'h96, 8'h94, 8'h04,
    8'h08, 8'h05, 8'h06, 8'hA3, 8'h14, 8'h18, 8'h15, 8'h16, 8'h58, 8'h55, 8'h56, 8'h54, 8'h52, 8'h48, 8'h45,
    8'h46, 8'h44, 8'h42, 8'h68, 8'h64, 8'h66, 8'h62, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hD4,
    8'hE8, 8'hE5, 8'hE6, 8'h74, 8'hF8, 8'hA8, 8'h78, 8'hF5, 8'h88, 8'h85, 8'h86, 8'h84, 8'hA4, 8'hA5};
  always #25 clock = ~clock;
  mae_core dut_u (.clock, .rstn, .issue, .opcode, .operand, .busy_ff, .done_ff, .cycles_ff, .result_ff,
    .result_wr_ff, .primary_operand_reg_ff, .second_operand_ff, .flag_word_register_ff, .data_pointer_pair_ff,
    .illegal_ff);
  // ********
  // compare, verdict and reference model
  // ********
  task automatic check(input logic [15:0] seen, input int exp);
    n_tests++;
    if (seen !== 16'(exp)) begin
      fail_count++;
      $display("BAD %0t op %h seen %h want %h", $time, opcode, seen, exp[15:0]);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic int lg(input int k, input int x, input int y);
    return k == 4 ? x | y : (k == 5 ? x & y : x ^ y);
  endfunction
  task automatic model(input int op, input int d, output int n, output int wr);
    int a, s, c;
    a = m_a;
    n = 1;
    wr = 0;
    m_il = 0;
    c = (op >> 4 == 3 || op >> 4 == 9) ? m_cy : 0;
    if (op inside {[8'h24:8'h2F], [8'h34:8'h3F], [8'h94:8'h9F]}) begin
      s = op > 8'h90 ? a - d - c : a + d + c;
      m_cy = op > 8'h90 ? s < 0 : s > 255;
      m_ac = op > 8'h90 ? a % 16 < d % 16 + c : a % 16 + d % 16 + c > 15;
      m_ov = (op > 8'h90 ? (a ^ d) & (a ^ s) : (a ^ s) & (d ^ s)) >> 7 & 1;
      m_a = s & 8'hFF;
      n = op[3] ? 1 : 2;
    end else if (op inside {[8'h44:8'h4F], [8'h54:8'h5F], [8'h64:8'h6F]}) begin
      m_a = lg(op >> 4, a, d);
      n = op[3] ? 1 : 2;
    end else if (op inside {8'h42, 8'h52, 8'h62}) begin
      m_r = lg(op >> 4, a, d);
      wr = 1;
      n = 3;
    end else if (op == 8'h04 || op == 8'h14) m_a = (a + (op == 8'h04 ? 1 : 255)) & 8'hFF;
    else if (op inside {[8'h05:8'h0F], [8'h15:8'h1F]}) begin
      m_r = (d + (op < 8'h10 ? 1 : 255)) & 8'hFF;
      wr = 1;
      n = op[3] ? 2 : 3;
    end else if (op == 8'hA3) m_dp = (m_dp + 1) & 16'hFFFF;
    else if (op inside {[8'hE5:8'hEF], 8'h74}) begin
      m_a = d;
      n = op inside {[8'hE8:8'hEF]} ? 1 : 2;
    end else if (op inside {[8'h78:8'h7F], [8'hF8:8'hFF], [8'h85:8'h8F], [8'hA8:8'hAF], 8'hF5}) begin
      m_r = op >= 8'hF5 ? a : d;
      wr = 1;
      n = op inside {[8'h85:8'h87], [8'hA8:8'hAF]} ? 4 : (op inside {[8'h78:8'h7F], [8'hF8:8'hFF]} ? 2 : 3);
    end else case (op)
      8'hE4: m_a = 0;
      8'hF4: m_a = a ^ 8'hFF;
      8'h23: m_a = (a << 1 | a >> 7) & 8'hFF;
      8'h03: m_a = (a >> 1 | a << 7) & 8'hFF;
      8'hC4: m_a = (a << 4 | a >> 4) & 8'hFF;
      8'h33, 8'h13: begin
        m_a = op == 8'h33 ? (a << 1 | m_cy) & 8'hFF : a >> 1 | m_cy << 7;
        m_cy = op == 8'h33 ? a >> 7 : a & 1;
      end
      8'hD4: begin
        if (a % 16 > 9 || m_ac) a += 6;
        if (a / 16 > 9 || m_cy) a += 8'h60;
        m_cy = m_cy | (a > 255);
        m_a = a & 8'hFF;
      end
      8'hA4: begin
        s = a * m_b;
        m_a = s & 8'hFF;
        m_b = s >> 8;
        m_cy = 0;
        m_ov = s > 255;
        n = 5;
      end
      8'h84: begin
        m_cy = 0;
        m_ov = m_b == 0;
        n = 5;
        if (m_b == 0) begin
          m_a = 8'hFF;
          m_b = a;
        end else begin
          m_a = a / m_b;
          m_b = a % m_b;
        end
      end
      default: m_il = 1;
    endcase
  endtask
  // ********
  // one instruction: issue, wait for completion, compare
  // ********
  task automatic exec(input int op, input int d, input bit junk);
    int n, wr, k;
    d = d & 8'hFF;
    opcode = op[7:0];
    operand = d[7:0];
    issue = 1'b1;
    model(op, d, n, wr);
    @(posedge clock);
    k = 0;
    do begin
      @(negedge clock);
      k++;
      if (k < n) check(busy_ff, 1);
      if (junk && !done_ff) opcode = 8'($random(seed));
    end while (!done_ff && k < 20);
    check(k, n);
    check(cycles_ff, n);
    check(primary_operand_reg_ff, m_a);
    check(second_operand_ff, m_b);
    check(flag_word_register_ff, m_cy * 128 + m_ac * 64 + m_ov * 4 + $countones(m_a) % 2);
    check(data_pointer_pair_ff, m_dp);
    check(illegal_ff, m_il);
    check(result_wr_ff, wr);
    if (wr) check(result_ff, m_r);
    if (!done_ff) end_of_test();
  endtask
  initial begin
    repeat (12) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    foreach (ops[i]) exec(ops[i], $random(seed), 1'b0);
    repeat (400) exec(ops[$unsigned($random(seed)) % ops.size()], $random(seed), 1'($random(seed)));
    issue = 1'b0;
    rstn = 1'b0;
    #1;
    check({busy_ff, done_ff, result_wr_ff, illegal_ff, cycles_ff, data_pointer_pair_ff[7:0]}, 0);
    check(primary_operand_reg_ff, 0);
    check(flag_word_register_ff, 0);
    check(second_operand_ff, 0);
    {m_a, m_b, m_cy, m_ac, m_ov, m_dp} = '0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 12; i++) exec(ops[i], $random(seed), 1'b1);
    issue = 1'b0;
    end_of_test();
  end
endmodule // mae_core_test
`default_nettype wire
